// ---- arc_pkg.sv ----
package arc_pkg;
    // register byte addresses, one aligned word each
    localparam logic [7:0] OFS_RESULT_LOW  = 8'h00;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h04;
    localparam logic [7:0] OFS_CTRL_A      = 8'h08;
    localparam logic [7:0] OFS_CTRL_B      = 8'h0c;
    localparam logic [7:0] OFS_DIS_LOW     = 8'h10;
    localparam logic [7:0] OFS_DIS_HIGH    = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h1c;

    // converter_control_a fields
    localparam int CA_ENABLE = 0;
    localparam int CA_START  = 1;
    localparam int CA_AUTO   = 2;
    localparam int CA_FLAG   = 3;
    localparam int CA_LEFT   = 4;
    localparam int CA_DIFF   = 5;
    localparam logic [7:0] CA_RESET = 8'h00;

    // converter_control_b fields; bits 7 and 5:4 reserved, read zero
    localparam int CB_TRIG_LSB = 0;
    localparam int CB_CHANNEL_SELECT_BIT5     = 3;
    localparam int CB_COMPARATOR_MUX_ENABLE     = 6;
    localparam logic [7:0] CB_WRITE_MASK = 8'h4f;
    localparam logic [7:0] CB_RESET      = 8'h00;
    localparam logic [7:0] DIS_RESET     = 8'h00;

    // interrupt status / mask layout
    localparam int IRQ_W    = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_TRIG = 1;

    localparam int RES_W      = 10;
    localparam int LEFT_SHIFT = 6;
    localparam int CNT_W      = 5;
    localparam logic [CNT_W-1:0] CONV_CYCLES_NORMAL = 5'd13;
    localparam logic [CNT_W-1:0] CONV_CYCLES_FIRST  = 5'd25;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        TRIG_FREE_RUN  = 3'b000,
        TRIG_COMPARE   = 3'b001,
        TRIG_EXT_INT0  = 3'b010,
        TRIG_T0_CMP_A  = 3'b011,
        TRIG_T0_OVF    = 3'b100,
        TRIG_T1_CMP_B  = 3'b101,
        TRIG_T1_OVF    = 3'b110,
        TRIG_T1_CAPT   = 3'b111
    } arc_trig_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } arc_state_t;

    // result word as software sees it
    function automatic logic [15:0] format_result(input logic [RES_W-1:0] code,
                                                  input logic left);
        format_result = left ? {code, {LEFT_SHIFT{1'b0}}} : {{LEFT_SHIFT{1'b0}}, code};
    endfunction : format_result
endpackage : arc_pkg

// ---- arc_trigger.sv ----
`timescale 1ns/1ps
`default_nettype none
module arc_trigger (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic [2:0] source_sel_in,
    input  wire logic [7:0] flags_in,
    output logic            edge_out
);
    logic       level_q;
    logic       level_d;
    logic [2:0] sel_q;
    logic       edge_d;

    always_comb begin
        level_d = flags_in[source_sel_in];
        // a rise, including one made by moving to a source already set
        edge_d  = level_d & ~level_q;
        // entering free run never fires on a flag that is already up
        if (source_sel_in == arc_pkg::TRIG_FREE_RUN && sel_q != arc_pkg::TRIG_FREE_RUN) begin
            edge_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            level_q  <= 1'b0;
            sel_q    <= arc_pkg::TRIG_FREE_RUN;
            edge_out <= 1'b0;
        end else begin
            level_q  <= level_d;
            sel_q    <= source_sel_in;
            edge_out <= edge_d;
        end
    end
endmodule : arc_trigger
`default_nettype wire

// ---- arc_top.sv ----
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - completed conversion loads result, differential two's complement
// - low byte read freezes result pair
// - left adjust to bits 15:6, else 9:0
// - trigger source ignored without auto trigger
// - auto trigger starts on selected flag rise
// - switching from clear to set source makes edge
// - switching to free run never triggers
// - trigger source encoding zero to seven
// - input disable forces pin reading zero
// - result and control registers reset zero
// - completion sets flag, drives free run
// - first conversion after enable 25 cycles
module arc_top (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RESET_IN,
    input  wire logic [7:0]  AWADDR_IN,
    input  wire logic        AWVALID_IN,
    output logic             AWREADY_OUT,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic [3:0]  WSTRB_IN,
    input  wire logic        WVALID_IN,
    output logic             WREADY_OUT,
    output logic [1:0]       BRESP_OUT,
    output logic             BVALID_OUT,
    input  wire logic        BREADY_IN,
    input  wire logic [7:0]  ARADDR_IN,
    input  wire logic        ARVALID_IN,
    output logic             ARREADY_OUT,
    output logic [31:0]      RDATA_OUT,
    output logic [1:0]       RRESP_OUT,
    output logic             RVALID_OUT,
    input  wire logic        RREADY_IN,
    input  wire logic        CONV_TICK_IN,
    input  wire logic [9:0]  CONV_CODE_IN,
    input  wire logic [6:0]  TRIG_FLAGS_IN,
    input  wire logic [15:0] PIN_RAW_IN,
    output logic [15:0]      PIN_READ_OUT,
    output logic [15:0]      INPUT_OFF_OUT,
    output logic             SAMPLE_START_OUT,
    output logic             CONV_BUSY_OUT,
    output logic             IRQ_OUT
);
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0]  aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0]  w_strb_q, w_strb_d;
    logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0]  bresp_d, rresp_d;
    logic [31:0] rdata_d;
    logic        do_write, do_read;
    localparam int IRQ_W_L = arc_pkg::IRQ_W;
    logic [7:0]            ctrl_a_q, ctrl_a_d;
    logic [7:0]            ctrl_b_q, ctrl_b_d;
    logic [7:0]            dis_low_q, dis_low_d, dis_high_q, dis_high_d;
    logic [IRQ_W_L-1:0]    irq_sts_q, irq_sts_d, irq_mask_q, irq_mask_d;
    logic [9:0]            result_q, result_d;
    logic                  lock_q, lock_d;
    logic                  irq_d;
    logic [15:0]           result_view;
    arc_pkg::arc_state_t   state_q, state_d;
    logic [4:0]            cnt_q, cnt_d;
    logic [4:0]            target_q, target_d;
    logic                  first_q, first_d;
    logic                  start_d, done, trig_edge, trig_start;
    logic [IRQ_W_L-1:0]    irq_evt, irq_clr;
    assign do_write = aw_have_q & w_have_q & ~BVALID_OUT;
    assign do_read  = ARVALID_IN & ARREADY_OUT;
    arc_trigger i_arc_trigger (
        .clk_in        (CLK_SYS_IN),
        .reset_in      (RESET_IN),
        .source_sel_in (ctrl_b_q[2:0]),
        .flags_in      ({TRIG_FLAGS_IN, ctrl_a_q[arc_pkg::CA_FLAG]}),
        .edge_out      (trig_edge)
    );
    // only honoured with auto trigger on and converter enabled
    assign trig_start = trig_edge & ctrl_a_q[arc_pkg::CA_AUTO]
                        & ctrl_a_q[arc_pkg::CA_ENABLE];
    assign done = (state_q == arc_pkg::ST_CONV) & CONV_TICK_IN & (cnt_q == target_q - 5'd1);
    assign result_view = arc_pkg::format_result(result_q, ctrl_a_q[arc_pkg::CA_LEFT]);
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
        merge_byte = strb[0] ? data[7:0] : old;
    endfunction : merge_byte
    // bus channels
    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        awready_d = 1'b0;
        wready_d  = 1'b0;
        bvalid_d  = BVALID_OUT & ~BREADY_IN;
        bresp_d   = BRESP_OUT;
        arready_d = 1'b0;
        rvalid_d  = RVALID_OUT & ~RREADY_IN;
        rresp_d   = RRESP_OUT;
        rdata_d   = RDATA_OUT;
        if (AWVALID_IN & AWREADY_OUT) begin
            aw_have_d = 1'b1;
            aw_addr_d = AWADDR_IN;
        end
        if (WVALID_IN & WREADY_OUT) begin
            w_have_d = 1'b1;
            w_data_d = WDATA_IN;
            w_strb_d = WSTRB_IN;
        end
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (aw_addr_q[7:2] <= arc_pkg::OFS_IRQ_MASK[7:2])
                        ? arc_pkg::RESP_OKAY : arc_pkg::RESP_SLVERR;
        end
        // one cycle ready pulses keep each channel to one beat per write
        awready_d = AWVALID_IN & ~AWREADY_OUT & ~aw_have_d & ~bvalid_d;
        wready_d  = WVALID_IN & ~WREADY_OUT & ~w_have_d & ~bvalid_d;
        if (do_read) begin
            rvalid_d = 1'b1;
            rresp_d  = arc_pkg::RESP_OKAY;
            unique case (ARADDR_IN[7:2])
                arc_pkg::OFS_RESULT_LOW[7:2]:  rdata_d = {24'h000000, result_view[7:0]};
                arc_pkg::OFS_RESULT_HIGH[7:2]: rdata_d = {24'h000000, result_view[15:8]};
                arc_pkg::OFS_CTRL_A[7:2]:     rdata_d = {24'h000000, ctrl_a_q};
                arc_pkg::OFS_CTRL_B[7:2]:     rdata_d = {24'h000000, ctrl_b_q};
                arc_pkg::OFS_DIS_LOW[7:2]:    rdata_d = {24'h000000, dis_low_q};
                arc_pkg::OFS_DIS_HIGH[7:2]:   rdata_d = {24'h000000, dis_high_q};
                arc_pkg::OFS_IRQ_STATUS[7:2]: rdata_d = {30'h00000000, irq_sts_q};
                arc_pkg::OFS_IRQ_MASK[7:2]:   rdata_d = {30'h00000000, irq_mask_q};
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = arc_pkg::RESP_SLVERR;
                end
            endcase
        end
        arready_d = ARVALID_IN & ~ARREADY_OUT & ~rvalid_d;
    end
    // registers, lock, conversion sequencing
    always_comb begin
        ctrl_a_d   = ctrl_a_q;
        ctrl_b_d   = ctrl_b_q;
        dis_low_d  = dis_low_q;
        dis_high_d = dis_high_q;
        irq_mask_d = irq_mask_q;
        result_d   = result_q;
        lock_d     = lock_q;
        state_d    = state_q;
        cnt_d      = cnt_q;
        target_d   = target_q;
        first_d    = first_q;
        start_d    = 1'b0;
        irq_evt    = '0;
        irq_clr    = '0;
        if (do_write && w_strb_q[0]) begin
            unique case (aw_addr_q)
                arc_pkg::OFS_CTRL_A: begin
                    ctrl_a_d = w_data_q[7:0];
                    // start reads back as busy, flag is write-one-to-clear
                    ctrl_a_d[arc_pkg::CA_START] = ctrl_a_q[arc_pkg::CA_START];
                    ctrl_a_d[arc_pkg::CA_FLAG]  = ctrl_a_q[arc_pkg::CA_FLAG]
                                                  & ~w_data_q[arc_pkg::CA_FLAG];
                    start_d = w_data_q[arc_pkg::CA_START];
                end
                arc_pkg::OFS_CTRL_B:
                    ctrl_b_d = w_data_q[7:0] & arc_pkg::CB_WRITE_MASK;
                arc_pkg::OFS_DIS_LOW:  dis_low_d  = merge_byte(dis_low_q, w_data_q, w_strb_q);
                arc_pkg::OFS_DIS_HIGH: dis_high_d = merge_byte(dis_high_q, w_data_q, w_strb_q);
                arc_pkg::OFS_IRQ_MASK: irq_mask_d = w_data_q[IRQ_W_L-1:0];
                default: ;
            endcase
        end
        if (do_read && ARADDR_IN == arc_pkg::OFS_RESULT_LOW) begin
            lock_d = 1'b1;
        end
        if (do_read && ARADDR_IN == arc_pkg::OFS_RESULT_HIGH) begin
            lock_d = 1'b0;
        end
        if (do_read && ARADDR_IN == arc_pkg::OFS_IRQ_STATUS) begin
            irq_clr = '1;
        end
        start_d = (start_d | trig_start) & ctrl_a_d[arc_pkg::CA_ENABLE];
        irq_evt[arc_pkg::IRQ_TRIG] = trig_start;
        if (!ctrl_a_q[arc_pkg::CA_ENABLE]) begin
            first_d = 1'b1;
        end
        unique case (state_q)
            arc_pkg::ST_IDLE: begin
                if (start_d) begin
                    state_d  = arc_pkg::ST_CONV;
                    cnt_d    = '0;
                    target_d = first_q ? arc_pkg::CONV_CYCLES_FIRST
                                       : arc_pkg::CONV_CYCLES_NORMAL;
                    first_d  = 1'b0;
                end
            end
            arc_pkg::ST_CONV: begin
                if (CONV_TICK_IN) begin
                    cnt_d = cnt_q + 5'd1;
                end
                if (done) begin
                    state_d = arc_pkg::ST_IDLE;
                    ctrl_a_d[arc_pkg::CA_FLAG] = 1'b1;
                    irq_evt[arc_pkg::IRQ_DONE] = 1'b1;
                    // front end gives offset binary; msb flip makes two's complement
                    if (!lock_d) begin
                        result_d = ctrl_a_q[arc_pkg::CA_DIFF]
                                   ? {~CONV_CODE_IN[9], CONV_CODE_IN[8:0]}
                                   : CONV_CODE_IN;
                    end
                end
            end
        endcase
        // disable aborts a conversion in flight
        if (!ctrl_a_d[arc_pkg::CA_ENABLE]) begin
            state_d = arc_pkg::ST_IDLE;
        end
        ctrl_a_d[arc_pkg::CA_START] = (state_d == arc_pkg::ST_CONV);
        irq_sts_d = (irq_sts_q & ~irq_clr) | irq_evt;
        irq_d     = |(irq_sts_d & irq_mask_d);
    end
    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            aw_have_q        <= 1'b0;
            aw_addr_q        <= 8'h00;
            w_have_q         <= 1'b0;
            w_data_q         <= 32'h00000000;
            w_strb_q         <= 4'h0;
            AWREADY_OUT      <= 1'b0;
            WREADY_OUT       <= 1'b0;
            BVALID_OUT       <= 1'b0;
            BRESP_OUT        <= arc_pkg::RESP_OKAY;
            ARREADY_OUT      <= 1'b0;
            RVALID_OUT       <= 1'b0;
            RRESP_OUT        <= arc_pkg::RESP_OKAY;
            RDATA_OUT        <= 32'h00000000;
            ctrl_a_q         <= arc_pkg::CA_RESET;
            ctrl_b_q         <= arc_pkg::CB_RESET;
            dis_low_q        <= arc_pkg::DIS_RESET;
            dis_high_q       <= arc_pkg::DIS_RESET;
            irq_sts_q        <= '0;
            irq_mask_q       <= '0;
            result_q         <= '0;
            lock_q           <= 1'b0;
            state_q          <= arc_pkg::ST_IDLE;
            cnt_q            <= '0;
            target_q         <= arc_pkg::CONV_CYCLES_NORMAL;
            first_q          <= 1'b1;
            PIN_READ_OUT     <= 16'h0000;
            INPUT_OFF_OUT    <= 16'h0000;
            SAMPLE_START_OUT <= 1'b0;
            CONV_BUSY_OUT    <= 1'b0;
            IRQ_OUT          <= 1'b0;
        end else begin
            aw_have_q        <= aw_have_d;
            aw_addr_q        <= aw_addr_d;
            w_have_q         <= w_have_d;
            w_data_q         <= w_data_d;
            w_strb_q         <= w_strb_d;
            AWREADY_OUT      <= awready_d;
            WREADY_OUT       <= wready_d;
            BVALID_OUT       <= bvalid_d;
            BRESP_OUT        <= bresp_d;
            ARREADY_OUT      <= arready_d;
            RVALID_OUT       <= rvalid_d;
            RRESP_OUT        <= rresp_d;
            RDATA_OUT        <= rdata_d;
            ctrl_a_q         <= ctrl_a_d;
            ctrl_b_q         <= ctrl_b_d;
            dis_low_q        <= dis_low_d;
            dis_high_q       <= dis_high_d;
            irq_sts_q        <= irq_sts_d;
            irq_mask_q       <= irq_mask_d;
            result_q         <= result_d;
            lock_q           <= lock_d;
            state_q          <= state_d;
            cnt_q            <= cnt_d;
            target_q         <= target_d;
            first_q          <= first_d;
            // one cycle of extra pin latency, registered like a port input
            PIN_READ_OUT     <= PIN_RAW_IN & ~{dis_high_d, dis_low_d};
            INPUT_OFF_OUT    <= {dis_high_d, dis_low_d};
            SAMPLE_START_OUT <= (state_q == arc_pkg::ST_IDLE) & (state_d == arc_pkg::ST_CONV);
            CONV_BUSY_OUT    <= (state_d == arc_pkg::ST_CONV);
            IRQ_OUT          <= irq_d;
        end
    end
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);
    a_lock_holds_result:
        assert property (lock_q && !(do_read && ARADDR_IN == arc_pkg::OFS_RESULT_HIGH)
                         |=> $stable(result_q))
        else $error("result changed while locked");
    a_high_read_unlocks:
        assert property (do_read && ARADDR_IN == arc_pkg::OFS_RESULT_HIGH |=> !lock_q)
        else $error("lock not released by high byte read");
    a_done_sets_flag:
        assert property (done && ctrl_a_d[arc_pkg::CA_ENABLE]
                         |=> ctrl_a_q[arc_pkg::CA_FLAG] && !CONV_BUSY_OUT)
        else $error("completion did not set flag");
    a_no_auto_no_trig:
        assert property (!ctrl_a_q[arc_pkg::CA_AUTO] && state_q == arc_pkg::ST_IDLE
                         && !(do_write && aw_addr_q == arc_pkg::OFS_CTRL_A)
                         |=> !CONV_BUSY_OUT)
        else $error("conversion started without auto trigger or start");
    a_trig_starts_conv:
        assert property (trig_start && state_q == arc_pkg::ST_IDLE
                         && ctrl_a_d[arc_pkg::CA_ENABLE] |=> CONV_BUSY_OUT ##0 SAMPLE_START_OUT)
        else $error("trigger edge did not start conversion");
    a_free_run_quiet:
        assert property (ctrl_b_q[2:0] == arc_pkg::TRIG_FREE_RUN
                         && $past(ctrl_b_q[2:0]) != arc_pkg::TRIG_FREE_RUN |=> !trig_edge)
        else $error("switch to free run fired a trigger");
    a_pin_masked:
        assert property (1'b1 |=> PIN_READ_OUT == ($past(PIN_RAW_IN) & ~INPUT_OFF_OUT))
        else $error("disabled pin reads one");
    a_first_conv_long:
        assert property (SAMPLE_START_OUT && $past(first_q)
                         |-> target_q == arc_pkg::CONV_CYCLES_FIRST)
        else $error("first conversion not lengthened");
    a_normal_conv_len:
        assert property (SAMPLE_START_OUT && !$past(first_q)
                         |-> target_q == arc_pkg::CONV_CYCLES_NORMAL)
        else $error("normal conversion length wrong");
    a_left_adjust_fmt:
        assert property (do_read && ARADDR_IN == arc_pkg::OFS_RESULT_HIGH
                         && ctrl_a_q[arc_pkg::CA_LEFT] |=> RDATA_OUT[7:0] == $past(result_q[9:2]))
        else $error("left adjusted high byte wrong");
    a_irq_level:
        assert property (1'b1 |-> IRQ_OUT == |(irq_sts_q & irq_mask_q))
        else $error("interrupt output mismatch");
endmodule : arc_top
`default_nettype wire

// ---- arc_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module arc_top_test;
    localparam logic [7:0] A_LO = arc_pkg::OFS_RESULT_LOW;
    localparam logic [7:0] A_HI = arc_pkg::OFS_RESULT_HIGH;
    localparam logic [7:0] A_CA = arc_pkg::OFS_CTRL_A;
    localparam logic [7:0] A_CB = arc_pkg::OFS_CTRL_B;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic        tick = 1'b0;
    logic [9:0]  code = 10'h000;
    logic [6:0]  flags = 7'h00;
    logic [15:0] raw = 16'h0000;
    logic        awready, wready, bvalid, arready, rvalid, start, busy, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, r;
    logic [15:0] pin_read, input_off;
    logic [9:0]  c, d;
    logic [65:0] notes[$];
    logic [65:0] note;
    int          failures = 0;
    int          tests_run = 0;
    int          starts = 0;
    int          ticks = 0;
    int          first;

    always #2.5 clk = ~clk;
    // converter clock at half the bus rate, free running
    always @(posedge clk) tick <= ~tick;

    arc_top i_arc_top (.CLK_SYS_IN(clk), .RESET_IN(rst), .AWADDR_IN(awaddr),
        .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(4'h1),
        .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
        .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
        .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
        .RVALID_OUT(rvalid), .RREADY_IN(rready), .CONV_TICK_IN(tick),
        .CONV_CODE_IN(code), .TRIG_FLAGS_IN(flags), .PIN_RAW_IN(raw),
        .PIN_READ_OUT(pin_read), .INPUT_OFF_OUT(input_off),
        .SAMPLE_START_OUT(start), .CONV_BUSY_OUT(busy), .IRQ_OUT(irq));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    // read results are judged by the watcher, oldest note first
    always @(posedge clk) begin
        if (start === 1'b1) starts++;
        if (tick === 1'b1 && busy === 1'b1) ticks++;
        if (rvalid === 1'b1 && rready) begin
            note = notes.pop_front();
            check("rdata", rdata & note[63:32], note[31:0]);
            check("rresp", {30'h0, rresp}, {30'h0, note[65:64]});
        end
    end

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [31:0] care = 32'hffffffff, input logic [1:0] resp = 2'b00);
        notes.push_back({resp, care, exp & care});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, 32'h0);
        @(posedge clk);
    endtask : wr

    // bounded wait for an idle converter, at least a few cycles for trigger latency
    task automatic settle;
        for (int i = 0; i < 200 && (i < 6 || busy !== 1'b0); i++) @(posedge clk);
    endtask : settle

    task automatic convert(input logic [9:0] v, input logic [7:0] ctl);
        code <= v;
        ticks = 0;
        wr(A_CA, ctl);
        settle();
    endtask : convert

    initial begin
        #300000;
        failures++;
        report_and_stop();
    end

    initial begin
        r = $urandom(84);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(A_LO, 32'h0);
        rd(A_HI, 32'h0);
        rd(A_CB, 32'h0);
        rd(arc_pkg::OFS_DIS_LOW, 32'h0);
        rd(arc_pkg::OFS_DIS_HIGH, 32'h0);
        rd(8'h20, 32'h0, 32'hffffffff, arc_pkg::RESP_SLVERR);
        r = $urandom;
        raw <= r[15:0];
        wr(arc_pkg::OFS_DIS_LOW, r[23:16]);
        wr(arc_pkg::OFS_DIS_HIGH, r[31:24]);
        rd(arc_pkg::OFS_DIS_HIGH, {24'h0, r[31:24]});
        check("pin_read", {16'h0, pin_read}, {16'h0, raw & ~r[31:16]});
        check("input_off", {16'h0, input_off}, {16'h0, r[31:16]});
        wr(arc_pkg::OFS_IRQ_MASK, 8'h01);
        c = 10'($urandom);
        convert(c, 8'h03);
        first = ticks;
        check("irq", {31'h0, irq}, 32'h1);
        rd(arc_pkg::OFS_IRQ_STATUS, 32'h1, 32'h1);
        check("irq", {31'h0, irq}, 32'h0);
        rd(A_LO, {24'h0, c[7:0]});
        rd(A_HI, {30'h0, c[9:8]});
        c = 10'($urandom);
        d = {~c[9], c[8:0]};
        convert(c, 8'h33);
        check("first_len", first - ticks, 32'd12);
        rd(A_LO, {24'h0, d[1:0], 6'h00});
        convert(~c, 8'h13);
        rd(A_HI, {24'h0, d[9:2]});
        convert(~c, 8'h13);
        rd(A_LO, {24'h0, ~c[1:0], 6'h00});
        rd(A_HI, {24'h0, ~c[9:2]});
        wr(A_CB, 8'h01);
        wr(A_CA, 8'h0d);
        for (int s = 1; s < 8; s++) begin
            wr(A_CB, 8'(s));
            starts = 0;
            flags <= ~(7'h01 << (s - 1));
            settle();
            check("wrong_src", starts, 32'd0);
            flags <= 7'h7f;
            settle();
            check("trig_start", starts, 32'd1);
            flags <= 7'h00;
            settle();
        end
        wr(A_CB, 8'h01);
        flags <= 7'h02;
        starts = 0;
        wr(A_CB, 8'h02);
        settle();
        check("switch_start", starts, 32'd1);
        starts = 0;
        flags <= 7'h00;
        wr(A_CB, 8'h00);
        settle();
        check("free_run", starts, 32'd0);
        wr(A_CA, 8'h01);
        wr(A_CB, 8'h01);
        flags <= 7'h00;
        settle();
        starts = 0;
        flags <= 7'h01;
        settle();
        check("auto_off", starts, 32'd0);
        report_and_stop();
    end
endmodule : arc_top_test
`default_nettype wire
